// ### core/serial_pin_pkg.sv
// constants and types for the serial port pin control block
package serial_pin_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 4;
  localparam int          DATA_W    = 16;
  localparam logic [3:0]  CTRL_ADDR = 4'h0;
  localparam logic [3:0]  GPIO_ADDR = 4'h1;
  localparam logic [3:0]  TXW_ADDR  = 4'h2;
  localparam logic [3:0]  RXW_ADDR  = 4'h3;
  localparam logic [3:0]  STAT_ADDR = 4'h4;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_START_BIT = 4;
  localparam int          GPIO_OE_LSB    = 4;
  localparam int          STAT_PIN_LSB   = 4;
  localparam logic [3:0]  CTRL_RESET     = 4'h0;
  localparam logic [2:0]  GPIO_RESET     = 3'h0;
  localparam logic [15:0] WORD_RESET     = 16'h0000;
  localparam logic [4:0]  FRAME_BITS_DEF = 5'h10;

  // ----------------------------------------------------------------
  // input synchroniser layout
  // ----------------------------------------------------------------
  localparam int          SYNC_N     = 6;
  localparam int          S_DEVRST   = 0;
  localparam int          S_OFF      = 1;
  localparam int          S_TXFS     = 2;
  localparam int          S_RXFS     = 3;
  localparam int          S_RXD      = 4;
  localparam int          S_BCLK     = 5;
  localparam logic [5:0]  SYNC_RESET = 6'h03;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tx_fs;
    logic rx_fs;
    logic tx_data;
  } pins_s;

  typedef struct packed {
    logic rx_fs_out;
    logic tx_fs_out;
    logic rx_gpio;
    logic tx_gpio;
  } ctrl_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;

  typedef enum logic {
    LINK_IDLE  = 1'b0,
    LINK_SHIFT = 1'b1
  } link_state_e;

endpackage

// ### core/serial_pin_ctrl.sv
// pin control, frame sync and shift logic of one serial port
`timescale 1ns/100ps

// What this block does
// - tx gpio enable set: transmit data pin becomes a general-purpose output; its input level is never read.
// - off input low: data and both frame sync pins go undriven.
// - receive frame sync pulse starts shifting in a frame from receive data.
// - rx gpio enable set: receive frame sync pin becomes general-purpose I/O.
// - transmit frame sync pulse starts shifting a frame out on transmit data.
// - device reset returns a transmit frame sync output to input mode while tx gpio enable is clear.
// - tx gpio enable set: transmit frame sync pin becomes general-purpose I/O.
module serial_pin_ctrl
#(
  parameter logic [4:0] FRAME_BITS = serial_pin_pkg::FRAME_BITS_DEF
)
(
  // clock and reset
  input  wire logic                                REF_CLK,
  input  wire logic                                SYS_RST,
  // register port
  input  wire serial_pin_pkg::bus_req_s            BUS_REQ,
  output wire logic [serial_pin_pkg::DATA_W-1:0]   RD_DATA,
  // device pins
  input  wire logic                                BIT_CLK,
  input  wire logic                                RX_DATA,
  input  wire logic                                OFF_N,
  input  wire logic                                DEVICE_RESET_N,
  input  wire serial_pin_pkg::pins_s               PIN_I,
  output wire serial_pin_pkg::pins_s               PIN_O,
  output wire serial_pin_pkg::pins_s               PIN_OE
);
  import serial_pin_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_N-1:0] raw;
  logic [SYNC_N-1:0] sync1_q;
  logic [SYNC_N-1:0] sync2_q;

  assign raw = {BIT_CLK, RX_DATA, PIN_I.rx_fs, PIN_I.tx_fs, OFF_N, DEVICE_RESET_N};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++)
    begin : g_sync
      always_ff @(posedge REF_CLK or posedge SYS_RST)
      begin
        if (SYS_RST)
        begin
          sync1_q[gi] <= SYNC_RESET[gi];
          sync2_q[gi] <= SYNC_RESET[gi];
        end
        else
        begin
          sync1_q[gi] <= raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic dev_rst_n_s;
  logic off_n_s;
  logic tx_fs_s;
  logic rx_fs_s;
  logic rx_d_s;
  logic bclk_prev_q;
  logic bclk_rise;

  assign dev_rst_n_s = sync2_q[S_DEVRST];
  assign off_n_s     = sync2_q[S_OFF];
  assign tx_fs_s     = sync2_q[S_TXFS];
  assign rx_fs_s     = sync2_q[S_RXFS];
  assign rx_d_s      = sync2_q[S_RXD];
  assign bclk_rise   = sync2_q[S_BCLK] & ~bclk_prev_q;

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      bclk_prev_q <= 1'b0;
    else
      bclk_prev_q <= sync2_q[S_BCLK];
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  ctrl_s       ctrl_q;
  pins_s       gpio_o_q;
  pins_s       gpio_oe_q;
  logic [15:0] tx_word_q;
  logic        wr_ctrl;
  logic        tx_start;

  assign wr_ctrl  = BUS_REQ.wr && (BUS_REQ.addr == CTRL_ADDR);
  assign tx_start = wr_ctrl && BUS_REQ.wdata[CTRL_START_BIT];

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      ctrl_q <= ctrl_s'(CTRL_RESET);
    else
    begin
      if (wr_ctrl)
        ctrl_q <= ctrl_s'(BUS_REQ.wdata[3:0]);
      if (!dev_rst_n_s)
        ctrl_q.tx_fs_out <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      gpio_o_q  <= pins_s'(GPIO_RESET);
      gpio_oe_q <= pins_s'(GPIO_RESET);
    end
    else if (BUS_REQ.wr && (BUS_REQ.addr == GPIO_ADDR))
    begin
      gpio_o_q  <= pins_s'(BUS_REQ.wdata[2:0]);
      gpio_oe_q <= pins_s'(BUS_REQ.wdata[GPIO_OE_LSB+2:GPIO_OE_LSB]);
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      tx_word_q <= WORD_RESET;
    else if (BUS_REQ.wr && (BUS_REQ.addr == TXW_ADDR))
      tx_word_q <= BUS_REQ.wdata;
  end

  // ----------------------------------------------------------------
  // internal frame sync generation
  // ----------------------------------------------------------------
  logic fs_pend_q;
  logic fs_drive_q;

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      fs_pend_q  <= 1'b0;
      fs_drive_q <= 1'b0;
    end
    else
    begin
      if (bclk_rise)
      begin
        fs_drive_q <= fs_pend_q;
        fs_pend_q  <= 1'b0;
      end
      if (tx_start)
        fs_pend_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------
  link_state_e tx_state_q;
  logic [15:0] tx_shift_q;
  logic [4:0]  tx_cnt_q;
  logic        tx_fs_seen;
  logic        tx_go;

  assign tx_fs_seen = ctrl_q.tx_fs_out ? fs_drive_q : tx_fs_s;
  assign tx_go      = bclk_rise && !ctrl_q.tx_gpio && tx_fs_seen;

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      tx_state_q <= LINK_IDLE;
      tx_shift_q <= WORD_RESET;
      tx_cnt_q   <= 5'h00;
    end
    else if (ctrl_q.tx_gpio || !dev_rst_n_s)
      tx_state_q <= LINK_IDLE;
    else
    begin
      case (tx_state_q)
        LINK_IDLE:
          if (tx_go)
          begin
            tx_shift_q <= tx_word_q;
            tx_cnt_q   <= FRAME_BITS;
            tx_state_q <= LINK_SHIFT;
          end
        LINK_SHIFT:
          if (bclk_rise)
          begin
            tx_shift_q <= {tx_shift_q[14:0], 1'b0};
            tx_cnt_q   <= tx_cnt_q - 5'h01;
            if (tx_cnt_q == 5'h01)
              tx_state_q <= LINK_IDLE;
          end
        default:
          tx_state_q <= LINK_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive shifter
  // ----------------------------------------------------------------
  link_state_e rx_state_q;
  logic [15:0] rx_shift_q;
  logic [15:0] rx_word_q;
  logic [4:0]  rx_cnt_q;
  logic        rx_done_q;
  logic        rx_fs_seen;
  logic        rx_go;
  logic        rx_last;
  logic        stat_rd;

  assign rx_fs_seen = ctrl_q.rx_fs_out ? fs_drive_q : rx_fs_s;
  assign rx_go      = bclk_rise && !ctrl_q.rx_gpio && rx_fs_seen;
  assign rx_last    = bclk_rise && (rx_state_q == LINK_SHIFT) && (rx_cnt_q == 5'h01);
  assign stat_rd    = BUS_REQ.rd && (BUS_REQ.addr == STAT_ADDR);

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rx_state_q <= LINK_IDLE;
      rx_shift_q <= WORD_RESET;
      rx_word_q  <= WORD_RESET;
      rx_cnt_q   <= 5'h00;
    end
    else if (ctrl_q.rx_gpio)
      rx_state_q <= LINK_IDLE;
    else
    begin
      case (rx_state_q)
        LINK_IDLE:
          if (rx_go)
          begin
            rx_cnt_q   <= FRAME_BITS;
            rx_state_q <= LINK_SHIFT;
          end
        LINK_SHIFT:
          if (bclk_rise)
          begin
            rx_shift_q <= {rx_shift_q[14:0], rx_d_s};
            rx_cnt_q   <= rx_cnt_q - 5'h01;
            if (rx_cnt_q == 5'h01)
            begin
              rx_word_q  <= {rx_shift_q[14:0], rx_d_s};
              rx_state_q <= LINK_IDLE;
            end
          end
        default:
          rx_state_q <= LINK_IDLE;
      endcase
    end
  end

  // done flag: a new frame beats a status read in the same cycle
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rx_done_q <= 1'b0;
    else if (rx_last && !ctrl_q.rx_gpio)
      rx_done_q <= 1'b1;
    else if (stat_rd)
      rx_done_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  pins_s pin_o_q;
  pins_s pin_oe_q;

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pin_o_q  <= pins_s'(3'h0);
      pin_oe_q <= pins_s'(3'h0);
    end
    else if (!off_n_s)
      pin_oe_q <= pins_s'(3'h0);
    else
    begin
      if (ctrl_q.tx_gpio)
      begin
        pin_o_q.tx_data  <= gpio_o_q.tx_data;
        pin_oe_q.tx_data <= gpio_oe_q.tx_data;
        pin_o_q.tx_fs    <= gpio_o_q.tx_fs;
        pin_oe_q.tx_fs   <= gpio_oe_q.tx_fs;
      end
      else
      begin
        pin_o_q.tx_data  <= tx_shift_q[15];
        pin_oe_q.tx_data <= 1'b1;
        pin_o_q.tx_fs    <= fs_drive_q;
        pin_oe_q.tx_fs   <= ctrl_q.tx_fs_out;
      end
      if (ctrl_q.rx_gpio)
      begin
        pin_o_q.rx_fs  <= gpio_o_q.rx_fs;
        pin_oe_q.rx_fs <= gpio_oe_q.rx_fs;
      end
      else
      begin
        pin_o_q.rx_fs  <= fs_drive_q;
        pin_oe_q.rx_fs <= ctrl_q.rx_fs_out;
      end
    end
  end

  assign PIN_O  = pin_o_q;
  assign PIN_OE = pin_oe_q;

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  logic [15:0] rd_data_q;
  logic [15:0] rd_mux;

  always_comb
  begin
    case (BUS_REQ.addr)
      CTRL_ADDR: rd_mux = {12'h000, ctrl_q};
      GPIO_ADDR: rd_mux = {9'h000, gpio_oe_q, 1'b0, gpio_o_q};
      TXW_ADDR:  rd_mux = tx_word_q;
      RXW_ADDR:  rd_mux = rx_word_q;
      STAT_ADDR: rd_mux = {8'h00, off_n_s, rx_d_s, rx_fs_s, tx_fs_s, 1'b0, rx_done_q,
                           rx_state_q == LINK_SHIFT, tx_state_q == LINK_SHIFT};
      default:   rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      rd_data_q <= 16'h0000;
    else if (BUS_REQ.rd)
      rd_data_q <= rd_mux;
    else
      rd_data_q <= 16'h0000;
  end

  assign RD_DATA = rd_data_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_OFF_RELEASE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !off_n_s |=> (pin_oe_q == pins_s'(3'h0)))
    else $error("pins driven while off is low");

  AST_TXD_GPIO: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    off_n_s && ctrl_q.tx_gpio |=> (pin_o_q.tx_data == $past(gpio_o_q.tx_data))
      && (pin_oe_q.tx_data == $past(gpio_oe_q.tx_data)))
    else $error("tx data pin not following gpio");

  AST_RXFS_GPIO: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    off_n_s && ctrl_q.rx_gpio |=> (pin_o_q.rx_fs == $past(gpio_o_q.rx_fs))
      && (pin_oe_q.rx_fs == $past(gpio_oe_q.rx_fs)))
    else $error("rx frame sync pin not following gpio");

  AST_TXFS_GPIO: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    off_n_s && ctrl_q.tx_gpio |=> (pin_o_q.tx_fs == $past(gpio_o_q.tx_fs))
      && (pin_oe_q.tx_fs == $past(gpio_oe_q.tx_fs)))
    else $error("tx frame sync pin not following gpio");

  AST_DEVRST_FS_IN: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !dev_rst_n_s && !ctrl_q.tx_gpio |=> !ctrl_q.tx_fs_out ##1 !pin_oe_q.tx_fs)
    else $error("tx frame sync still an output after device reset");

  AST_RX_START: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    rx_go && (rx_state_q == LINK_IDLE) |=> (rx_state_q == LINK_SHIFT)
      && (rx_cnt_q == FRAME_BITS))
    else $error("receive frame sync did not start a frame");

  AST_TX_START: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    tx_go && dev_rst_n_s && (tx_state_q == LINK_IDLE) |=> (tx_state_q == LINK_SHIFT)
      && (tx_shift_q == $past(tx_word_q)))
    else $error("transmit frame sync did not start a frame");

  AST_SERIAL_ROLE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    off_n_s && !ctrl_q.tx_gpio |=> pin_oe_q.tx_data
      && (pin_o_q.tx_data == $past(tx_shift_q[15]))
      && (pin_oe_q.tx_fs == $past(ctrl_q.tx_fs_out)))
    else $error("serial role not kept with gpio disabled");

  AST_RX_ROLE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    off_n_s && !ctrl_q.rx_gpio |=> (pin_o_q.rx_fs == $past(fs_drive_q))
      && (pin_oe_q.rx_fs == $past(ctrl_q.rx_fs_out)))
    else $error("rx frame sync role not kept with gpio disabled");

endmodule

// ### testbench/serial_peer.sv
// external serial peer: bit clock, frame sync, receive data, transmit capture
`timescale 1ns/100ps

module serial_peer
(
  // pin level seen on the transmit data line
  input  wire logic        tx_pin,
  // pins driven by the peer
  output logic             bclk,
  output logic             fs,
  output logic             rxd,
  // word captured in the last frame
  output logic [15:0]      cap
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  localparam realtime HALF = 62.5;

  initial
  begin
    bclk = 1'b0;
    fs   = 1'b0;
    rxd  = 1'b0;
    cap  = 16'h0000;
  end

  // ----------------------------------------------------------------
  // one frame: sync over the start rise, then 16 bits each way
  // ----------------------------------------------------------------
  task automatic frame(input logic [15:0] word);
    integer i;
    fs = 1'b1;
    #HALF bclk = 1'b1;
    #HALF bclk = 1'b0;
    fs = 1'b0;
    for (i = 15; i >= 0; i--)
    begin
      cap[i] = tx_pin;
      rxd = word[i];
      #HALF bclk = 1'b1;
      #HALF bclk = 1'b0;
    end
    rxd = ~rxd;
  endtask

  // one bit clock period with no frame, lets an internal sync go out
  task automatic tick;
    #HALF bclk = 1'b1;
    #HALF bclk = 1'b0;
  endtask
endmodule

// ### testbench/serial_port_pin_control_bench.sv
// self-checking bench for the serial port pin control block
`timescale 1ns/100ps
`define CHK(a, e) cmp_count++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %0t bad %h", $time, a); end

module serial_port_pin_control_bench;
  import serial_pin_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                   ref_clk;
  logic                   sys_rst;
  logic                   off_n;
  logic                   device_reset_n;
  bus_req_s               req;
  logic [DATA_W-1:0]      rd_data;
  pins_s                  pin_i;
  pins_s                  pin_o;
  pins_s                  pin_oe;
  logic                   bclk;
  logic                   peer_fs;
  logic                   peer_rxd;
  logic                   tx_wire;
  logic [15:0]            peer_cap;
  int                     bad_count;
  int                     cmp_count;

  // wire levels from the dut's enables; the peer's fs fills each sync pin the dut does not drive
  assign tx_wire = pin_oe.tx_data ? pin_o.tx_data : 1'bz;
  assign pin_i   = {pin_oe.tx_fs ? pin_o.tx_fs : peer_fs,
                    pin_oe.rx_fs ? pin_o.rx_fs : peer_fs, tx_wire};

  serial_pin_ctrl i_dut
  (
    .REF_CLK        (ref_clk),
    .SYS_RST        (sys_rst),
    .BUS_REQ        (req),
    .RD_DATA        (rd_data),
    .BIT_CLK        (bclk),
    .RX_DATA        (peer_rxd),
    .OFF_N          (off_n),
    .DEVICE_RESET_N (device_reset_n),
    .PIN_I          (pin_i),
    .PIN_O          (pin_o),
    .PIN_OE         (pin_oe)
  );

  serial_peer i_peer
  (
    .tx_pin (tx_wire),
    .bclk   (bclk),
    .fs     (peer_fs),
    .rxd    (peer_rxd),
    .cap    (peer_cap)
  );

  // ----------------------------------------------------------------
  // clock, bus tasks, closing
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge ref_clk);
    req.wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge ref_clk);
    req.rd   <= 1'b0;
    #1;
    `CHK(rd_data & m, e)
    @(posedge ref_clk);
  endtask

  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    bad_count++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    bad_count      = 0;
    cmp_count      = 0;
    sys_rst        = 1'b1;
    off_n          = 1'b1;
    device_reset_n = 1'b1;
    req            = '0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // reset values and an unmapped address
    rd(CTRL_ADDR, 16'h000f, 16'h0000);
    rd(GPIO_ADDR, 16'h0077, 16'h0000);
    rd(TXW_ADDR, 16'hffff, 16'h0000);
    rd(RXW_ADDR, 16'hffff, 16'h0000);
    rd(4'h5, 16'hffff, 16'h0000);
    `CHK(pin_oe, 3'b001)
    // serial frame both ways on an external sync
    wr(TXW_ADDR, 16'hc3a5);
    i_peer.frame(16'h5a3c);
    `CHK(peer_cap, 16'hc3a5)
    rd(RXW_ADDR, 16'hffff, 16'h5a3c);
    rd(STAT_ADDR, 16'h0007, 16'h0004);
    rd(STAT_ADDR, 16'h0007, 16'h0000);
    // both sides as general-purpose pins, frame refused
    wr(CTRL_ADDR, 16'h0003);
    wr(GPIO_ADDR, 16'h0075);
    repeat (3) @(posedge ref_clk);
    `CHK(pin_oe, 3'b111)
    `CHK(pin_o, 3'b101)
    // rx sync pin released to the peer, so a refused frame is really offered
    wr(GPIO_ADDR, 16'h0055);
    repeat (3) @(posedge ref_clk);
    `CHK(pin_oe, 3'b101)
    wr(TXW_ADDR, 16'h0f0f);
    i_peer.frame(16'h1234);
    `CHK(pin_o, 3'b101)
    rd(RXW_ADDR, 16'hffff, 16'h5a3c);
    rd(STAT_ADDR, 16'h0007, 16'h0000);
    // off input forces every pin undriven
    off_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    `CHK(pin_oe, 3'b000)
    off_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    `CHK(pin_oe, 3'b101)
    // internal frame sync drives both sync pins
    wr(TXW_ADDR, 16'h96e1);
    wr(CTRL_ADDR, 16'h001c);
    repeat (3) @(posedge ref_clk);
    `CHK(pin_oe, 3'b111)
    i_peer.tick;
    i_peer.frame(16'h6b19);
    `CHK(peer_cap, 16'h96e1)
    rd(RXW_ADDR, 16'hffff, 16'h6b19);
    // transmit sync as output, then device reset
    wr(CTRL_ADDR, 16'h0004);
    repeat (3) @(posedge ref_clk);
    `CHK(pin_oe, 3'b101)
    device_reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    `CHK(pin_oe, 3'b001)
    rd(CTRL_ADDR, 16'h000f, 16'h0000);
    device_reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    tally_and_finish;
  end
endmodule
